// [driver_protection_defs.vh]
`ifndef DRIVER_PROTECTION_DEFS_VH
`define DRIVER_PROTECTION_DEFS_VH

// Clock rate
`define CLK_MHZ             100

// Input register field positions
`define IN_FAULT_CLEAR_BIT  0
`define IN_OUT_LSB          1
`define IN_OUT_MSB          6
`define IN_OPEN_LOAD_BIT    13
`define IN_DELAY_SEL_BIT    14
`define IN_STANDBY_BIT      15

// Input register value after power-on reset
`define IN_RESET_VALUE      16'he000

// Output register field positions
`define OUT_TEMP_WARN_BIT   0
`define OUT_STATUS_LSB      1
`define OUT_STATUS_MSB      6
`define OUT_SHORT_BIT       13
`define OUT_INHIBIT_BIT     14
`define OUT_SUPPLY_BIT      15
`define OUT_ALL_HIGH        16'hffff

// Delay times in microseconds
`define SHORT_LONG_US       100000
`define SHORT_SHORT_US      12500
`define SUPPLY_LONG_US      14000
`define SUPPLY_SHORT_US     3500

// Delay counts in clock cycles
`define SHORT_LONG_CYC      (`SHORT_LONG_US * `CLK_MHZ)
`define SHORT_SHORT_CYC     (`SHORT_SHORT_US * `CLK_MHZ)
`define SUPPLY_LONG_CYC     (`SUPPLY_LONG_US * `CLK_MHZ)
`define SUPPLY_SHORT_CYC    (`SUPPLY_SHORT_US * `CLK_MHZ)

`endif

// [fault_delay_timer.v]
module fault_delay_timer #(
  parameter W = 24
) (
  input  wire         CLK,
  input  wire         RSTN,
  input  wire         ACTIVE,
  input  wire [W-1:0] LIMIT,
  output reg          DONE
);

  reg [W-1:0] count_reg;

  // Restarts from zero whenever the fault condition goes away
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      count_reg <= {W{1'b0}};
      DONE      <= 1'b0;
    end else if (!ACTIVE) begin
      count_reg <= {W{1'b0}};
      DONE      <= 1'b0;
    end else if (count_reg + {{(W-1){1'b0}}, 1'b1} >= LIMIT) begin
      DONE      <= 1'b1;
    end else begin
      count_reg <= count_reg + {{(W-1){1'b0}}, 1'b1};
    end
  end

endmodule // fault_delay_timer

// [driver_protection_diagnosis.v]
`include "driver_protection_defs.vh"

module driver_protection_diagnosis #(
  parameter NOUT             = 6,
  parameter TW               = 24,
  parameter [TW-1:0] SHORT_LONG_CYC   = `SHORT_LONG_CYC,
  parameter [TW-1:0] SHORT_SHORT_CYC  = `SHORT_SHORT_CYC,
  parameter [TW-1:0] SUPPLY_LONG_CYC  = `SUPPLY_LONG_CYC,
  parameter [TW-1:0] SUPPLY_SHORT_CYC = `SUPPLY_SHORT_CYC
) (
  input  wire            CLK,
  input  wire            RSTN,
  input  wire            CS_N,
  input  wire            INPUT_WRITE,
  input  wire [15:0]     INPUT_WORD,
  input  wire            LOAD_SUPPLY_OVER,
  input  wire            LOAD_SUPPLY_UNDER,
  input  wire            TEMP_ABOVE_WARN_SET,
  input  wire            TEMP_BELOW_WARN_RESET,
  input  wire            TEMP_ABOVE_SHUTDOWN,
  input  wire [NOUT-1:0] CURRENT_LIMIT,
  input  wire [NOUT-1:0] OPEN_LOAD_SENSE,
  input  wire            HW_INHIBIT_PIN,
  output reg  [NOUT-1:0] OUT_ENABLE,
  output reg  [NOUT-1:0] TEST_CURRENT_EN,
  output reg  [15:0]     OUTPUT_WORD,
  output reg  [15:0]     INPUT_REG,
  output reg             SERIAL_DATA_OUT,
  output wire            SUPPLY_FAIL_FLAG,
  output wire            TEMP_WARNING_FLAG,
  output wire            SHORT_DETECTED_FLAG,
  output wire            INHIBIT_STATUS
);

  // Input register fields
  wire            fault_clear_request;
  wire [NOUT-1:0] out_cmd;
  wire            open_load_test_n;
  wire            fault_delay_select;
  wire            soft_standby_n;

  reg             supply_fail_reg;
  reg             supply_fail_next;
  reg             supply_off_reg;
  reg             supply_off_next;
  reg             temp_warn_reg;
  reg             temp_warn_next;
  reg             shutdown_reg;
  reg             shutdown_next;
  reg             short_flag_reg;
  reg             short_flag_next;
  reg [NOUT-1:0]  short_off_reg;
  reg [NOUT-1:0]  short_off_next;
  reg [NOUT-1:0]  open_load_next;
  reg             cs_n_reg;
  reg [NOUT-1:0]  enable_next;
  reg [NOUT-1:0]  test_next;
  reg [15:0]      out_word_next;

  wire            supply_bad;
  wire            supply_done;
  wire [TW-1:0]   supply_limit;
  wire [TW-1:0]   short_limit;
  wire [NOUT-1:0] short_done;
  wire [NOUT-1:0] short_active;
  wire            inhibit;
  wire            clear_pulse;
  wire            detect_on;
  wire            cs_fall;

  // One loop variable per process, so no variable has two drivers
  integer i;
  integer j;
  integer k;

  // Picks one of two delay counts from the select bit
  function [TW-1:0] pick_delay;
    input          sel;
    input [TW-1:0] long_cyc;
    input [TW-1:0] short_cyc;
    begin
      pick_delay = sel ? long_cyc : short_cyc;
    end
  endfunction

  assign fault_clear_request = INPUT_REG[`IN_FAULT_CLEAR_BIT];
  assign out_cmd             = INPUT_REG[`IN_OUT_MSB:`IN_OUT_LSB];
  assign open_load_test_n    = INPUT_REG[`IN_OPEN_LOAD_BIT];
  assign fault_delay_select  = INPUT_REG[`IN_DELAY_SEL_BIT];
  assign soft_standby_n      = INPUT_REG[`IN_STANDBY_BIT];

  // Clear acts once per completed write carrying the bit
  assign clear_pulse = INPUT_WRITE & INPUT_WORD[`IN_FAULT_CLEAR_BIT];

  // Either path alone puts the stages in standby
  assign inhibit = ~soft_standby_n | ~HW_INHIBIT_PIN;

  assign supply_bad = LOAD_SUPPLY_OVER | LOAD_SUPPLY_UNDER;

  assign supply_limit = pick_delay(fault_delay_select, SUPPLY_LONG_CYC,
                                   SUPPLY_SHORT_CYC);
  assign short_limit  = pick_delay(fault_delay_select, SHORT_LONG_CYC,
                                   SHORT_SHORT_CYC);

  assign detect_on = ~open_load_test_n & soft_standby_n;

  assign cs_fall = cs_n_reg & ~CS_N;

  assign SUPPLY_FAIL_FLAG    = supply_fail_reg;
  assign TEMP_WARNING_FLAG   = temp_warn_reg;
  assign SHORT_DETECTED_FLAG = short_flag_reg;
  assign INHIBIT_STATUS      = OUTPUT_WORD[`OUT_INHIBIT_BIT];

  fault_delay_timer #(
    .W (TW)
  ) supply_timer (
    .CLK    (CLK),
    .RSTN   (RSTN),
    .ACTIVE (supply_bad),
    .LIMIT  (supply_limit),
    .DONE   (supply_done)
  );

  // Timer runs only while the stage is actually on and limiting
  assign short_active = CURRENT_LIMIT & OUT_ENABLE;

  genvar g;
  generate
    for (g = 0; g < NOUT; g = g + 1) begin : g_short
      fault_delay_timer #(
        .W (TW)
      ) short_timer (
        .CLK    (CLK),
        .RSTN   (RSTN),
        .ACTIVE (short_active[g]),
        .LIMIT  (short_limit),
        .DONE   (short_done[g])
      );
    end
  endgenerate

  // Supply fault state
  always @* begin
    supply_off_next  = supply_off_reg;
    supply_fail_next = supply_fail_reg;
    if (!supply_bad) begin
      supply_off_next = 1'b0;
    end else if (supply_done) begin
      supply_off_next = 1'b1;
    end
    if (clear_pulse) begin
      supply_fail_next = 1'b0;
    end
    // Set wins over a clear in the same cycle
    if (supply_bad && supply_done) begin
      supply_fail_next = 1'b1;
    end
  end

  // Temperature warning and shutdown
  always @* begin
    temp_warn_next = temp_warn_reg;
    if (TEMP_ABOVE_WARN_SET) begin
      temp_warn_next = 1'b1;
    end else if (TEMP_BELOW_WARN_RESET) begin
      temp_warn_next = 1'b0;
    end
    shutdown_next = shutdown_reg;
    if (TEMP_ABOVE_SHUTDOWN) begin
      shutdown_next = 1'b1;
    end else if (clear_pulse) begin
      shutdown_next = 1'b0;
    end
  end

  // Short-circuit latches per output
  always @* begin
    short_off_next  = short_off_reg;
    short_flag_next = short_flag_reg;
    if (clear_pulse) begin
      short_off_next  = {NOUT{1'b0}};
      short_flag_next = 1'b0;
    end
    for (i = 0; i < NOUT; i = i + 1) begin
      if (short_active[i] && short_done[i]) begin
        short_off_next[i] = 1'b1;
        short_flag_next   = 1'b1;
      end
      // Warning during a short skips the delay
      if (short_active[i] && temp_warn_reg) begin
        short_off_next[i] = 1'b1;
        short_flag_next   = 1'b1;
      end
    end
  end

  // Open-load detection and test currents
  always @* begin
    test_next      = {NOUT{1'b0}};
    open_load_next = {NOUT{1'b0}};
    for (j = 0; j < NOUT; j = j + 1) begin
      // A commanded-on stage masks its own detection only
      if (detect_on && !out_cmd[j]) begin
        test_next[j]      = 1'b1;
        open_load_next[j] = OPEN_LOAD_SENSE[j];
      end
    end
  end

  // Output stage enables
  always @* begin
    enable_next = out_cmd & ~short_off_next;
    if (inhibit) begin
      enable_next = {NOUT{1'b0}};
    end
    if (supply_off_next) begin
      enable_next = {NOUT{1'b0}};
    end
    if (shutdown_next) begin
      enable_next = {NOUT{1'b0}};
    end
  end

  // Output register contents
  always @* begin
    out_word_next = 16'h0000;
    out_word_next[`OUT_TEMP_WARN_BIT] = temp_warn_next;
    for (k = 0; k < NOUT; k = k + 1) begin
      if (test_next[k]) begin
        out_word_next[`OUT_STATUS_LSB + k] = open_load_next[k];
      end else begin
        out_word_next[`OUT_STATUS_LSB + k] = enable_next[k];
      end
    end
    out_word_next[`OUT_SHORT_BIT]   = short_flag_next;
    out_word_next[`OUT_INHIBIT_BIT] = inhibit;
    out_word_next[`OUT_SUPPLY_BIT]  = supply_fail_next;
    if (shutdown_next) begin
      out_word_next = `OUT_ALL_HIGH;
    end
  end

  // Input register: only a completed transfer loads it
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      INPUT_REG <= `IN_RESET_VALUE;
    end else if (INPUT_WRITE) begin
      INPUT_REG <= INPUT_WORD;
    end
  end

  // Protection state
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      supply_fail_reg <= 1'b0;
      supply_off_reg  <= 1'b0;
      temp_warn_reg   <= 1'b0;
      shutdown_reg    <= 1'b0;
      short_flag_reg  <= 1'b0;
      short_off_reg   <= {NOUT{1'b0}};
    end else begin
      supply_fail_reg <= supply_fail_next;
      supply_off_reg  <= supply_off_next;
      temp_warn_reg   <= temp_warn_next;
      shutdown_reg    <= shutdown_next;
      short_flag_reg  <= short_flag_next;
      short_off_reg   <= short_off_next;
    end
  end

  // Driven outputs; stages off during reset
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      OUT_ENABLE      <= {NOUT{1'b0}};
      TEST_CURRENT_EN <= {NOUT{1'b0}};
      OUTPUT_WORD     <= 16'h0000;
    end else begin
      OUT_ENABLE      <= enable_next;
      TEST_CURRENT_EN <= test_next;
      OUTPUT_WORD     <= out_word_next;
    end
  end

  // Early warning read: chip select fall presents the flag at the next clock edge
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      cs_n_reg        <= 1'b1;
      SERIAL_DATA_OUT <= 1'b0;
    end else begin
      cs_n_reg <= CS_N;
      if (cs_fall) begin
        SERIAL_DATA_OUT <= temp_warn_reg;
      end
    end
  end

endmodule // driver_protection_diagnosis

// [driver_protection_diagnosis_props.sv]
module driver_protection_props (
  input logic        CLK,
  input logic        RSTN,
  input logic        CS_N,
  input logic        INPUT_WRITE,
  input logic [15:0] INPUT_WORD,
  input logic        LOAD_SUPPLY_OVER,
  input logic        LOAD_SUPPLY_UNDER,
  input logic        TEMP_ABOVE_WARN_SET,
  input logic        TEMP_BELOW_WARN_RESET,
  input logic        TEMP_ABOVE_SHUTDOWN,
  input logic        HW_INHIBIT_PIN,
  input logic [5:0]  OUT_ENABLE,
  input logic [15:0] OUTPUT_WORD,
  input logic [15:0] INPUT_REG,
  input logic        SERIAL_DATA_OUT,
  input logic        SUPPLY_FAIL_FLAG,
  input logic        TEMP_WARNING_FLAG,
  input logic        SHORT_DETECTED_FLAG,
  input logic        INHIBIT_STATUS
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  wire bad = LOAD_SUPPLY_OVER | LOAD_SUPPLY_UNDER;
  wire clr = INPUT_WRITE & INPUT_WORD[0];
  // Short delay assumes eight cycles, as the bench sets it
  sequence bad_short8;
    (bad && !INPUT_REG[14])[*8];
  endsequence
  sequence bad_more4;
    bad[*4];
  endsequence
  a_supply_fail_delay: assert property (bad_short8 ##1 bad_more4 |->
    SUPPLY_FAIL_FLAG && OUT_ENABLE == 6'h00) else $error("supply fail late");
  a_supply_flag_sticky: assert property (SUPPLY_FAIL_FLAG && !clr |=> SUPPLY_FAIL_FLAG)
    else $error("supply flag dropped");
  a_short_flag_sticky: assert property (SHORT_DETECTED_FLAG && !clr |=> SHORT_DETECTED_FLAG)
    else $error("short flag dropped");
  a_warn_flag_set: assert property (TEMP_ABOVE_WARN_SET |=> TEMP_WARNING_FLAG)
    else $error("warning flag not set");
  a_warn_flag_clear: assert property (TEMP_BELOW_WARN_RESET && !TEMP_ABOVE_WARN_SET
    |=> !TEMP_WARNING_FLAG) else $error("warning flag not cleared");
  a_early_warn_read: assert property ($fell(CS_N) |=>
    SERIAL_DATA_OUT == $past(TEMP_WARNING_FLAG)) else $error("early read wrong");
  a_input_reg_hold: assert property (!INPUT_WRITE |=> $stable(INPUT_REG))
    else $error("input register changed");
  a_thermal_all_high: assert property (TEMP_ABOVE_SHUTDOWN |=>
    OUTPUT_WORD == 16'hffff && OUT_ENABLE == 6'h00) else $error("shutdown wrong");
  a_inhibit_outputs_off: assert property (!HW_INHIBIT_PIN || !INPUT_REG[15] |=>
    OUT_ENABLE == 6'h00) else $error("outputs on in standby");
  a_inhibit_status_bit: assert property (!HW_INHIBIT_PIN |=> INHIBIT_STATUS)
    else $error("inhibit status low");
endmodule // driver_protection_props

bind driver_protection_diagnosis driver_protection_props driver_protection_props_i (.*);

// [host_model.sv]
module host_model (
  input  logic        CLK,
  input  logic        SERIAL_DATA_OUT,
  output logic        CS_N,
  output logic        INPUT_WRITE,
  output logic [15:0] INPUT_WORD
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    CS_N = 1'b1;
    INPUT_WRITE = 1'b0;
    INPUT_WORD = 16'h5a5a;
  end
  task send(input logic [15:0] w);
    @(posedge CLK);
    CS_N <= 1'b0;
    INPUT_WRITE <= 1'b1;
    INPUT_WORD <= w;
    @(posedge CLK);
    CS_N <= 1'b1;
    INPUT_WRITE <= 1'b0;
    INPUT_WORD <= ~w;  // Idle bus never shows the last word
  endtask
  task peek(output logic b);
    @(posedge CLK);
    CS_N <= 1'b0;
    repeat (3) @(posedge CLK);
    b = SERIAL_DATA_OUT;
    CS_N <= 1'b1;
  endtask
endmodule // host_model

// [driver_protection_diagnosis_tb_top.sv]
module driver_protection_diagnosis_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, rstn = 1'b0, ovr = 1'b0, und = 1'b0, wset = 1'b0;
  logic        wrst = 1'b1, tsd = 1'b0, hw_inhibit_pin = 1'b1, b;
  logic [5:0]  lim = 6'h00, ols = 6'h00, oe, tce;
  logic [15:0] ow, ir, iw;
  logic        cs_n, iwr, sdo, sff, twf, sdf, ist;
  int          failures = 0;
  int          checks = 0;
  wire [15:0]  st = {6'h0, sff, sdf, twf, ist, oe};
  always #5 clk = ~clk;
  driver_protection_diagnosis #(.SHORT_LONG_CYC(20), .SHORT_SHORT_CYC(10),
    .SUPPLY_LONG_CYC(16), .SUPPLY_SHORT_CYC(8)) driver_protection_diagnosis_i (
    .CLK(clk), .RSTN(rstn), .CS_N(cs_n), .INPUT_WRITE(iwr), .INPUT_WORD(iw),
    .LOAD_SUPPLY_OVER(ovr), .LOAD_SUPPLY_UNDER(und), .TEMP_ABOVE_WARN_SET(wset),
    .TEMP_BELOW_WARN_RESET(wrst), .TEMP_ABOVE_SHUTDOWN(tsd), .CURRENT_LIMIT(lim),
    .OPEN_LOAD_SENSE(ols), .HW_INHIBIT_PIN(hw_inhibit_pin), .OUT_ENABLE(oe), .TEST_CURRENT_EN(tce),
    .OUTPUT_WORD(ow), .INPUT_REG(ir), .SERIAL_DATA_OUT(sdo), .SUPPLY_FAIL_FLAG(sff),
    .TEMP_WARNING_FLAG(twf), .SHORT_DETECTED_FLAG(sdf), .INHIBIT_STATUS(ist));
  host_model host_model_i (.CLK(clk), .SERIAL_DATA_OUT(sdo), .CS_N(cs_n),
    .INPUT_WRITE(iwr), .INPUT_WORD(iw));
  task chk(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task final_report;
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #100us;
    failures++;
    final_report;
  end
  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    cyc(2);
    chk(ir, 16'he000);
    chk(st, 16'h000);
    host_model_i.send(16'ha00e);
    cyc(3);
    chk(st, 16'h007);
    @(posedge clk) hw_inhibit_pin <= 1'b0;
    cyc(3);
    chk(st, 16'h040);
    @(posedge clk) hw_inhibit_pin <= 1'b1;
    cyc(3);
    chk(st, 16'h007);
    host_model_i.send(16'h200e);
    cyc(3);
    chk(st, 16'h040);
    $display("test inhibit done");
    host_model_i.send(16'ha00e);
    @(posedge clk) und <= 1'b1;
    cyc(5);
    chk(st, 16'h007);
    cyc(9);
    chk(st, 16'h200);
    @(posedge clk) und <= 1'b0;
    cyc(3);
    chk(st, 16'h207);
    host_model_i.send(16'ha00f);
    cyc(3);
    chk(st, 16'h007);
    host_model_i.send(16'he00e);
    @(posedge clk) ovr <= 1'b1;
    cyc(12);
    chk(st, 16'h007);
    cyc(12);
    chk(st, 16'h200);
    @(posedge clk) ovr <= 1'b0;
    host_model_i.send(16'he00f);
    cyc(3);
    chk(st, 16'h007);
    $display("test supply done");
    @(posedge clk) lim <= 6'h02;
    cyc(15);
    chk(st, 16'h007);
    cyc(12);
    chk(st, 16'h105);
    @(posedge clk) lim <= 6'h00;
    host_model_i.send(16'he00f);
    cyc(3);
    chk(st, 16'h007);
    @(posedge clk);
    lim <= 6'h3d;
    wset <= 1'b1;
    wrst <= 1'b0;
    cyc(4);
    chk(st, 16'h182);
    host_model_i.peek(b);
    chk(16'(b), 16'h1);
    chk(ir, 16'he00f);
    @(posedge clk);
    lim <= 6'h00;
    wset <= 1'b0;
    wrst <= 1'b1;
    cyc(3);
    chk(st, 16'h102);
    host_model_i.send(16'he00f);
    cyc(3);
    chk(st, 16'h007);
    $display("test short done");
    @(posedge clk) tsd <= 1'b1;
    cyc(3);
    chk(ow, 16'hffff);
    chk(16'(oe), 16'h0);
    @(posedge clk) tsd <= 1'b0;
    cyc(3);
    chk(16'(oe), 16'h0);
    host_model_i.send(16'he00f);
    cyc(3);
    chk(st, 16'h007);
    $display("test thermal done");
    @(posedge clk) ols <= 6'h3f;
    host_model_i.send(16'h8000);
    cyc(3);
    chk({4'h0, tce, ow[6:1]}, 16'hfff);
    host_model_i.send(16'h8002);
    cyc(3);
    chk(16'(tce), 16'h3e);
    host_model_i.send(16'h0000);
    cyc(3);
    chk(16'(tce), 16'h0);
    $display("test open load done");
    final_report;
  end
endmodule // driver_protection_diagnosis_tb_top
